//--- hw/fms_map.svh
// Purpose: Offsets-free constant map for the flyback mode sequencer: timing and fault counts.
// Assumes: mclk period given by FMS_CLK_NS; all times below are in nanoseconds.
// Notes:   Least times round up to whole cycles, longest times round down.
`ifndef FMS_MAP_SVH
`define FMS_MAP_SVH

`define FMS_CLK_NS          10
`define FMS_TBLANK_QR_NS    6200
`define FMS_TBLANK_VS_NS    38000
`define FMS_TFORCE_NS       6000
`define FMS_TON_MAX_NS      20000
`define FMS_TSU_NS          20000000
`define FMS_FAULT_CYCLES    4
`define FMS_CYC_UP(ns)      ((((ns) + `FMS_CLK_NS - 1) / `FMS_CLK_NS) < 1 ? 1 : \
	(((ns) + `FMS_CLK_NS - 1) / `FMS_CLK_NS))
`define FMS_CYC_DN(ns)      (((ns) / `FMS_CLK_NS) < 1 ? 1 : ((ns) / `FMS_CLK_NS))

`endif

//--- hw/fms_pkg.sv
// Purpose: Types shared by the flyback mode sequencer.
// Assumes: Nothing beyond the constant map.
// Notes:   Sense bits are raw comparator decisions, asynchronous to mclk.
`default_nettype none

package fms_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_CHARGE, ST_SOFT, ST_ACTIVE, ST_STOP} fms_state_t;
	typedef enum logic [1:0] {GP_OFF, GP_ON, GP_BLANK, GP_WAIT} fms_phase_t;
	typedef enum logic [1:0] {MD_NONE, MD_QR, MD_VALLEY, MD_BURST} fms_mode_t;
	typedef struct packed {
		logic hvAbove;
		logic vddOn;
		logic vddAboveOff;
		logic vddAboveRestart;
		logic fbInRange;
		logic fbAboveFreqRed;
		logic fbAboveBurst;
		logic zcdArm;
		logic zcdTrig;
		logic peakTrip;
		logic ovpCmp;
		logic uvpCmp;
		logic ocpFault;
		logic otpFault;
		logic latchVariant;
	} fms_sense_t;
endpackage : fms_pkg

`default_nettype wire

//--- hw/fms_flyback_mode_sequencer.sv
// Purpose: Start-up, operating-mode and fault sequencer of a quasi-resonant flyback controller.
// Assumes: All sense inputs are comparator outputs from outside the mclk domain.
// Notes:   Sense inputs and the reset release each pass two flops before use.
// Function
// - Input above start threshold enables the high-voltage start-up source.
// - Supply above turn-on disables start-up source and starts gate switching.
// - Start-up begins in constant-current operation, giving soft start.
// - Leave start-up for active operation once feedback reaches regulating range.
// - Undervoltage fault detection is suppressed throughout the soft-start period.
// - Undervoltage fault only after four consecutive low switching cycles.
// - Heavy load: turn-on follows the negative demagnetization edge unless the FORCE timeout expires first.
// - Medium or light load: longer blanking moves turn-on to later valleys.
// - Very light load: bursts at fixed peak separated by idle intervals.
// - Any fault or supply below turn-off stops switching, then restarts.
// - Auto-restart clears fault when supply drops below restart threshold.
// - Only overvoltage may be latched, by variant; other faults auto-restart.
// - Latched overvoltage waits for input below start and supply below restart.
// - Overvoltage fault only after four consecutive high switching cycles.
`include "fms_map.svh"
`default_nettype none

module fms_flyback_mode_sequencer #(
	parameter int unsigned SOFT_START_CYC = `FMS_CYC_UP(`FMS_TSU_NS)
) (
	input  wire logic               mclk,
	input  wire logic               rst_b,
	input  wire logic               ce,
	input  wire fms_pkg::fms_sense_t senseRaw,
	output var  logic               hvSourceEn,
	output var  logic               gateDrive,
	output var  logic               ccSoftStart,
	output var  fms_pkg::fms_mode_t activeMode,
	output var  fms_pkg::fms_state_t seqState,
	output var  logic               ovpFault,
	output var  logic               uvpFault
);

	localparam int unsigned SSW = $clog2(SOFT_START_CYC + 1);
	localparam logic [15:0] TON_MAX  = 16'(`FMS_CYC_DN(`FMS_TON_MAX_NS));
	localparam logic [15:0] BLANK_QR = 16'(`FMS_CYC_UP(`FMS_TBLANK_QR_NS));
	localparam logic [15:0] BLANK_VS = 16'(`FMS_CYC_UP(`FMS_TBLANK_VS_NS));
	localparam logic [15:0] FORCE    = 16'(`FMS_CYC_UP(`FMS_TFORCE_NS));
	localparam logic [2:0]  NFAULT   = 3'(`FMS_FAULT_CYCLES);
	localparam logic [SSW-1:0] SS_END = SSW'(SOFT_START_CYC);

	////////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers.

	logic                rstMetaN_q;
	logic                rstSyncN_q;
	fms_pkg::fms_sense_t senseMeta_q;
	fms_pkg::fms_sense_t sense_q;
	logic                trigPrev_q;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstMetaN_q <= 1'b0;
			rstSyncN_q <= 1'b0;
		end else begin
			rstMetaN_q <= 1'b1;
			rstSyncN_q <= rstMetaN_q;
		end
	end

	always_ff @(posedge mclk or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			senseMeta_q <= '0;
			sense_q     <= '0;
			trigPrev_q  <= 1'b0;
		end else if (ce) begin
			senseMeta_q <= senseRaw;
			sense_q     <= senseMeta_q;
			trigPrev_q  <= sense_q.zcdTrig;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state.

	fms_pkg::fms_state_t state_q, state_d;
	fms_pkg::fms_phase_t phase_q, phase_d;
	fms_pkg::fms_mode_t  mode_q, mode_d;
	logic [15:0]         cnt_q, cnt_d;
	logic [SSW-1:0]      ssCnt_q, ssCnt_d;
	logic [2:0]          ovpCnt_q, ovpCnt_d;
	logic [2:0]          uvpCnt_q, uvpCnt_d;
	logic                armed_q, armed_d;
	logic                gate_q, gate_d;
	logic                hvEn_q, hvEn_d;
	logic                cc_q, cc_d;
	logic                ovpF_q, ovpF_d;
	logic                uvpF_q, uvpF_d;
	logic                othF_q, othF_d;
	logic                latchVar_q, latchVar_d;
	logic                running;
	logic                stopNow;
	logic                ssDone;
	logic                trigEdge;
	logic                burstIdle;
	logic [15:0]         blankLim;

	// A stuck comparator saturates the count instead of wrapping past the limit.
	function automatic logic [2:0] countFault(input logic hit, input logic [2:0] c);
		if (!hit)
			return 3'h0;
		return (c == NFAULT) ? c : c + 3'h1;
	endfunction : countFault

	function automatic fms_pkg::fms_mode_t pickMode(input fms_pkg::fms_sense_t s);
		if (s.fbAboveFreqRed)
			return fms_pkg::MD_QR;
		if (s.fbAboveBurst)
			return fms_pkg::MD_VALLEY;
		return fms_pkg::MD_BURST;
	endfunction : pickMode

	always_comb begin
		state_d    = state_q;
		phase_d    = phase_q;
		cnt_d      = cnt_q;
		ssCnt_d    = ssCnt_q;
		ovpCnt_d   = ovpCnt_q;
		uvpCnt_d   = uvpCnt_q;
		armed_d    = armed_q;
		gate_d     = gate_q;
		ovpF_d     = ovpF_q;
		uvpF_d     = uvpF_q;
		othF_d     = othF_q;
		latchVar_d = latchVar_q;
		running    = (state_q == fms_pkg::ST_SOFT) || (state_q == fms_pkg::ST_ACTIVE);
		ssDone     = (ssCnt_q == SS_END);
		trigEdge   = sense_q.zcdTrig && !trigPrev_q;
		burstIdle  = (mode_q == fms_pkg::MD_BURST) && !sense_q.fbAboveBurst;
		// Long blanking outside heavy load is what skips to later valleys.
		blankLim   = (mode_q == fms_pkg::MD_VALLEY || mode_q == fms_pkg::MD_BURST) ?
			BLANK_VS : BLANK_QR;
		stopNow    = running && (ovpF_q || uvpF_q || othF_q || !sense_q.vddAboveOff);

		case (state_q)
			fms_pkg::ST_IDLE: begin
				// The variant strap is only re-read while nothing switches.
				latchVar_d = sense_q.latchVariant;
				if (sense_q.hvAbove)
					state_d = fms_pkg::ST_CHARGE;
			end
			fms_pkg::ST_CHARGE: begin
				if (!sense_q.hvAbove)
					state_d = fms_pkg::ST_IDLE;
				else if (sense_q.vddOn) begin
					state_d = fms_pkg::ST_SOFT;
					phase_d = fms_pkg::GP_OFF;
				end
			end
			fms_pkg::ST_SOFT, fms_pkg::ST_ACTIVE: begin
				if (state_q == fms_pkg::ST_SOFT && sense_q.fbInRange)
					state_d = fms_pkg::ST_ACTIVE;
				if (!ssDone)
					ssCnt_d = ssCnt_q + 1'b1;
				if (sense_q.ocpFault || sense_q.otpFault)
					othF_d = 1'b1;
				cnt_d = cnt_q + 16'h1;
				case (phase_q)
					fms_pkg::GP_ON: begin
						if (sense_q.peakTrip || cnt_q >= TON_MAX - 16'h1) begin
							gate_d  = 1'b0;
							phase_d = fms_pkg::GP_BLANK;
							cnt_d   = 16'h0;
							armed_d = 1'b0;
						end
					end
					fms_pkg::GP_BLANK: begin
						// Edges here are leakage ringing and must not trigger.
						if (sense_q.zcdArm)
							armed_d = 1'b1;
						if (cnt_q >= blankLim - 16'h1) begin
							phase_d = fms_pkg::GP_WAIT;
							cnt_d   = 16'h0;
						end
					end
					fms_pkg::GP_WAIT: begin
						if (sense_q.zcdArm)
							armed_d = 1'b1;
						if ((armed_q && trigEdge) || cnt_q >= FORCE - 16'h1) begin
							phase_d = fms_pkg::GP_OFF;
							cnt_d   = 16'h0;
						end
					end
					default: begin
						cnt_d = 16'h0;
					end
				endcase
				// Turn-on is the single overvoltage and undervoltage sampling point of each cycle.
				if (phase_q == fms_pkg::GP_OFF && !burstIdle && !stopNow) begin
					ovpCnt_d = countFault(sense_q.ovpCmp, ovpCnt_q);
					uvpCnt_d = countFault(sense_q.uvpCmp && ssDone, uvpCnt_q);
					if (ovpCnt_d == NFAULT)
						ovpF_d = 1'b1;
					if (uvpCnt_d == NFAULT)
						uvpF_d = 1'b1;
					if (!ovpF_d && !uvpF_d) begin
						gate_d  = 1'b1;
						phase_d = fms_pkg::GP_ON;
						cnt_d   = 16'h0;
					end
				end
				if (stopNow) begin
					state_d = fms_pkg::ST_STOP;
					gate_d  = 1'b0;
					phase_d = fms_pkg::GP_OFF;
				end
			end
			fms_pkg::ST_STOP: begin
				if (ovpF_q && latchVar_q) begin
					if (!sense_q.hvAbove && !sense_q.vddAboveRestart)
						state_d = fms_pkg::ST_IDLE;
				end else if (ovpF_q || uvpF_q || othF_q) begin
					if (!sense_q.vddAboveRestart)
						state_d = fms_pkg::ST_IDLE;
				end else
					state_d = fms_pkg::ST_IDLE;
				if (state_d == fms_pkg::ST_IDLE) begin
					ovpF_d = 1'b0;
					uvpF_d = 1'b0;
					othF_d = 1'b0;
				end
			end
			default: begin
				state_d = fms_pkg::ST_IDLE;
			end
		endcase

		if (state_d != fms_pkg::ST_SOFT && state_d != fms_pkg::ST_ACTIVE) begin
			ssCnt_d  = '0;
			ovpCnt_d = 3'h0;
			uvpCnt_d = 3'h0;
			gate_d   = 1'b0;
			cnt_d    = 16'h0;
			phase_d  = fms_pkg::GP_OFF;
		end
		hvEn_d = (state_d == fms_pkg::ST_CHARGE);
		cc_d   = (state_d == fms_pkg::ST_SOFT);
		mode_d = (state_d == fms_pkg::ST_ACTIVE) ? pickMode(sense_q) : fms_pkg::MD_NONE;
	end

	always_ff @(posedge mclk or negedge rstSyncN_q) begin
		if (!rstSyncN_q) begin
			state_q    <= fms_pkg::ST_IDLE;
			phase_q    <= fms_pkg::GP_OFF;
			mode_q     <= fms_pkg::MD_NONE;
			cnt_q      <= 16'h0;
			ssCnt_q    <= '0;
			ovpCnt_q   <= 3'h0;
			uvpCnt_q   <= 3'h0;
			armed_q    <= 1'b0;
			gate_q     <= 1'b0;
			hvEn_q     <= 1'b0;
			cc_q       <= 1'b0;
			ovpF_q     <= 1'b0;
			uvpF_q     <= 1'b0;
			othF_q     <= 1'b0;
			latchVar_q <= 1'b0;
		end else if (ce) begin
			state_q    <= state_d;
			phase_q    <= phase_d;
			mode_q     <= mode_d;
			cnt_q      <= cnt_d;
			ssCnt_q    <= ssCnt_d;
			ovpCnt_q   <= ovpCnt_d;
			uvpCnt_q   <= uvpCnt_d;
			armed_q    <= armed_d;
			gate_q     <= gate_d;
			hvEn_q     <= hvEn_d;
			cc_q       <= cc_d;
			ovpF_q     <= ovpF_d;
			uvpF_q     <= uvpF_d;
			othF_q     <= othF_d;
			latchVar_q <= latchVar_d;
		end
	end

	assign hvSourceEn  = hvEn_q;
	assign gateDrive   = gate_q;
	assign ccSoftStart = cc_q;
	assign activeMode  = mode_q;
	assign seqState    = state_q;
	assign ovpFault    = ovpF_q;
	assign uvpFault    = uvpF_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstSyncN_q);

	sequence seqCharge;
		ce && state_q == fms_pkg::ST_CHARGE && sense_q.hvAbove && sense_q.vddOn;
	endsequence
	sequence seqSwitching;
		!hvEn_q && state_q == fms_pkg::ST_SOFT;
	endsequence

	chk_hv_enable: assert property (ce && state_q == fms_pkg::ST_IDLE && sense_q.hvAbove
		|=> hvEn_q && state_q == fms_pkg::ST_CHARGE) else $error("start source not on");
	chk_start_switch: assert property (seqCharge |=> seqSwitching ##1 ce[*1] ##[0:8] gate_q)
		else $error("switching did not start");
	chk_soft_cc: assert property ($rose(state_q == fms_pkg::ST_SOFT) |-> cc_q && !gate_q)
		else $error("soft start not in cc");
	chk_leave_soft: assert property (ce && state_q == fms_pkg::ST_SOFT && sense_q.fbInRange
		&& !stopNow |=> state_q == fms_pkg::ST_ACTIVE && !cc_q) else $error("soft not left");
	chk_uvp_mask: assert property (running && !ssDone |-> uvpCnt_q == 3'h0 && !uvpF_q)
		else $error("uvp counted in soft start");
	chk_uvp_count: assert property ($rose(uvpF_q) |-> uvpCnt_q == NFAULT && !gate_q
		&& $past(phase_q) == fms_pkg::GP_OFF) else $error("uvp before four cycles");
	chk_ovp_count: assert property ($rose(ovpF_q) |-> ovpCnt_q == NFAULT && !gate_q
		&& $past(phase_q) == fms_pkg::GP_OFF) else $error("ovp before four cycles");
	chk_blank_off: assert property (phase_q == fms_pkg::GP_BLANK |-> !gate_q)
		else $error("gate on during blanking");
	chk_valley_gap: assert property ($fell(gate_q) && mode_q == fms_pkg::MD_VALLEY
		|-> !gate_q[*8]) else $error("valley skip too short");
	chk_burst_idle: assert property (ce && burstIdle && phase_q == fms_pkg::GP_OFF
		&& state_q == fms_pkg::ST_ACTIVE |=> !gate_q) else $error("switching in idle");
	chk_stop_gate: assert property (ce && stopNow |=> state_q == fms_pkg::ST_STOP && !gate_q)
		else $error("no stop on fault");
	chk_auto_clear: assert property (ce && state_q == fms_pkg::ST_STOP && !latchVar_q
		&& !sense_q.vddAboveRestart |=> state_q == fms_pkg::ST_IDLE && !uvpF_q && !ovpF_q)
		else $error("auto restart missing");
	chk_ovp_latch: assert property (state_q == fms_pkg::ST_STOP && ovpF_q && latchVar_q
		&& sense_q.hvAbove |=> state_q == fms_pkg::ST_STOP) else $error("latch released");
	chk_fault_sample: assert property (ce && phase_q == fms_pkg::GP_OFF && !burstIdle
		&& running && !stopNow && !sense_q.ovpCmp |=> ovpCnt_q == 3'h0) else $error("ovp count kept");

endmodule : fms_flyback_mode_sequencer

`default_nettype wire

//--- dv/fms_converter_model.sv
// Purpose: Behavioural flyback power stage as seen from the gate and sense pins.
// Assumes: Gate is a level from the sequencer, sampled after each rising mclk.
// Notes:   The auxiliary winding rings with a 100-cycle period while the switch is off.
`default_nettype none

module fms_converter_model #(
	parameter int ON_CYC = 20
) (
	input  wire logic mclk,
	input  wire logic gateDrive,
	output var  logic peakTrip,
	output var  logic zcdArm,
	output var  logic zcdTrig
);
	timeunit 1ns;
	timeprecision 1ns;

	int ring = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Outputs move 2 ns after the edge so that the bench, sampling at 1 ns, never races them.
	initial begin
		peakTrip = 1'h0;
		zcdArm   = 1'h0;
		zcdTrig  = 1'h0;
		forever begin
			@(posedge mclk);
			#2;
			if (gateDrive === 1'h1) begin
				zcdArm  = 1'h0;
				zcdTrig = 1'h0;
				repeat (ON_CYC) @(posedge mclk);
				#2;
				peakTrip = 1'h1;
				while (gateDrive === 1'h1) begin
					@(posedge mclk);
					#2;
				end
				peakTrip = 1'h0;
				ring     = 0;
			end else begin
				ring    = (ring + 1) % 100;
				zcdArm  = ring < 40;
				zcdTrig = ring >= 60 && ring < 90;
			end
		end
	end
endmodule : fms_converter_model

`default_nettype wire

//--- dv/testbench.sv
// Purpose: Self-checking bench for the flyback mode sequencer.
// Assumes: Soft-start timer shortened to 20000 cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic                mclk        = 1'h0;
	logic                rst_b       = 1'h0;
	fms_pkg::fms_sense_t tbSense     = '0;
	fms_pkg::fms_sense_t senseRaw;
	logic                peakTrip, zcdArm, zcdTrig, hvSourceEn, gateDrive;
	logic                ccSoftStart, ovpFault, uvpFault;
	fms_pkg::fms_mode_t  activeMode;
	fms_pkg::fms_state_t seqState;
	int                  miscompares = 0;
	int                  checksDone  = 0;
	int                  cycles      = 0;

	always #5 mclk = ~mclk;

	always_comb begin
		senseRaw          = tbSense;
		senseRaw.peakTrip = peakTrip;
		senseRaw.zcdArm   = zcdArm;
		senseRaw.zcdTrig  = zcdTrig;
	end

	fms_flyback_mode_sequencer #(.SOFT_START_CYC(20000)) i_dut (
		.mclk(mclk), .rst_b(rst_b), .ce(1'h1), .senseRaw(senseRaw),
		.hvSourceEn(hvSourceEn), .gateDrive(gateDrive), .ccSoftStart(ccSoftStart),
		.activeMode(activeMode), .seqState(seqState), .ovpFault(ovpFault),
		.uvpFault(uvpFault)
	);

	fms_converter_model #(.ON_CYC(20)) i_conv (
		.mclk(mclk), .gateDrive(gateDrive), .peakTrip(peakTrip), .zcdArm(zcdArm),
		.zcdTrig(zcdTrig)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc

	task automatic wait_state(input fms_pkg::fms_state_t s);
		int n = 0;
		while (seqState !== s && n < 40000) begin
			cyc(1);
			n++;
		end
		check("seqState", s, seqState);
	endtask : wait_state

	task automatic wait_gate(input logic lvl);
		int n = 0;
		while (gateDrive !== lvl && n < 9000) begin
			cyc(1);
			n++;
		end
		check("gateDrive", lvl, gateDrive);
	endtask : wait_gate

	// Off time of the next switch-off, and cycles since the last trigger edge at turn-on.
	task automatic gap(input int lim, output int off, output int since);
		logic prevTrig;
		wait_gate(1'h0);
		off      = 0;
		since    = 999;
		prevTrig = zcdTrig;
		while (gateDrive !== 1'h1 && off < lim) begin
			cyc(1);
			off++;
			since    = (zcdTrig && !prevTrig) ? 0 : since + 1;
			prevTrig = zcdTrig;
		end
	endtask : gap

	task automatic count_rises(input logic useOvp, input int most, output int rises);
		logic prevGate;
		int   n = 0;
		rises    = 0;
		prevGate = gateDrive;
		while ((useOvp ? ovpFault : uvpFault) !== 1'h1 && rises < most && n < 20000) begin
			cyc(1);
			n++;
			rises += (gateDrive && !prevGate) ? 1 : 0;
			prevGate = gateDrive;
		end
	endtask : count_rises

	task automatic power_down(input logic hv);
		tbSense.vddOn           = 1'h0;
		tbSense.vddAboveOff     = 1'h0;
		tbSense.vddAboveRestart = 1'h0;
		tbSense.fbInRange       = 1'h0;
		tbSense.hvAbove         = hv;
	endtask : power_down

	task automatic bring_up(input logic latch);
		tbSense.latchVariant   = latch;
		tbSense.fbAboveFreqRed = 1'h1;
		tbSense.fbAboveBurst   = 1'h1;
		tbSense.hvAbove        = 1'h1;
		wait_state(fms_pkg::ST_CHARGE);
		check("hvSourceEn", 1'h1, hvSourceEn);
		tbSense.vddAboveRestart = 1'h1;
		tbSense.vddAboveOff     = 1'h1;
		tbSense.vddOn           = 1'h1;
		wait_state(fms_pkg::ST_SOFT);
		check("hvSourceEn", 1'h0, hvSourceEn);
		check("ccSoftStart", 1'h1, ccSoftStart);
		wait_gate(1'h1);
		tbSense.fbInRange = 1'h1;
		wait_state(fms_pkg::ST_ACTIVE);
		check("ccSoftStart", 1'h0, ccSoftStart);
	endtask : bring_up

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_soft;
		logic seen = 1'h0;
		tbSense.uvpCmp = 1'h1;
		bring_up(1'h0);
		repeat (15000) begin
			cyc(1);
			seen |= uvpFault;
		end
		check("uvpFault", 1'h0, seen);
		tbSense.uvpCmp = 1'h0;
		cyc(6000);
	endtask : t_soft

	task automatic t_modes;
		int off, since;
		check("activeMode", fms_pkg::MD_QR, activeMode);
		gap(9000, off, since);
		check("zcdToGate", 1'h1, since <= 6);
		tbSense.fbAboveFreqRed = 1'h0;
		cyc(5);
		check("activeMode", fms_pkg::MD_VALLEY, activeMode);
		gap(9000, off, since);
		gap(9000, off, since);
		check("valleyOff", 1'h1, off >= 3700);
		tbSense.fbAboveBurst = 1'h0;
		cyc(5);
		check("activeMode", fms_pkg::MD_BURST, activeMode);
		gap(8000, off, since);
		check("burstIdle", 1'h1, off >= 8000);
		tbSense.fbAboveBurst   = 1'h1;
		tbSense.fbAboveFreqRed = 1'h1;
		wait_gate(1'h1);
	endtask : t_modes

	task automatic t_uvp;
		int r;
		wait_gate(1'h0);
		tbSense.uvpCmp = 1'h1;
		count_rises(1'h0, 2, r);
		tbSense.uvpCmp = 1'h0;
		count_rises(1'h0, 1, r);
		check("uvpFault", 1'h0, uvpFault);
		wait_gate(1'h0);
		tbSense.uvpCmp = 1'h1;
		count_rises(1'h0, 99, r);
		check("uvpRises", 3, r);
		cyc(2);
		check("seqState", fms_pkg::ST_STOP, seqState);
		cyc(1000);
		check("gateDrive", 1'h0, gateDrive);
		tbSense.uvpCmp = 1'h0;
		power_down(1'h1);
		wait_state(fms_pkg::ST_IDLE);
		check("uvpFault", 1'h0, uvpFault);
		wait_state(fms_pkg::ST_CHARGE);
	endtask : t_uvp

	task automatic t_ovp_latched;
		int r;
		power_down(1'h0);
		wait_state(fms_pkg::ST_IDLE);
		bring_up(1'h1);
		wait_gate(1'h0);
		tbSense.ovpCmp = 1'h1;
		count_rises(1'h1, 99, r);
		check("ovpRises", 3, r);
		tbSense.ovpCmp = 1'h0;
		power_down(1'h1);
		cyc(300);
		check("seqState", fms_pkg::ST_STOP, seqState);
		tbSense.hvAbove = 1'h0;
		wait_state(fms_pkg::ST_IDLE);
		check("ovpFault", 1'h0, ovpFault);
	endtask : t_ovp_latched

	task automatic t_ocp_vdd;
		bring_up(1'h1);
		tbSense.ocpFault = 1'h1;
		wait_state(fms_pkg::ST_STOP);
		tbSense.ocpFault = 1'h0;
		power_down(1'h1);
		wait_state(fms_pkg::ST_IDLE);
		bring_up(1'h0);
		tbSense.vddAboveOff = 1'h0;
		tbSense.vddOn       = 1'h0;
		wait_state(fms_pkg::ST_IDLE);
		check("gateDrive", 1'h0, gateDrive);
		wait_state(fms_pkg::ST_CHARGE);
	endtask : t_ocp_vdd

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge mclk);
		#1;
		check("seqState", fms_pkg::ST_IDLE, seqState);
		check("gateDrive", 1'h0, gateDrive);
		rst_b = 1'h1;
		cyc(3);
		t_soft();
		t_modes();
		t_uvp();
		t_ovp_latched();
		t_ocp_vdd();
		stop_test();
	end
endmodule : testbench

`default_nettype wire
